// ---- common/urfc_pkg.sv ----
/*
   Constants, types and helpers of the UART rate generator and frame check.
   Assumes one system clock and word-indexed register addressing.
*/
package urfc_pkg;

   localparam int unsigned ADR_W           = 12;
   localparam int unsigned DAT_W           = 32;
   localparam int unsigned CNT_W           = 8;
   localparam int unsigned PRESCALE_DIV    = 6;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_RELOAD      = 8'h9A;
   localparam logic [7:0] IDX_CONTROL     = 8'h9B;
   localparam logic [7:0] IDX_SERIAL      = 8'h9C;
   localparam logic [7:0] IDX_POWER       = 8'h9D;
   localparam logic [7:0] IDX_TIMER2      = 8'h9E;
   localparam logic [7:0] IDX_COUNT       = 8'h9F;

   // Control register fields
   localparam int unsigned CTL_SRC        = 0;
   localparam int unsigned CTL_SPEED      = 1;
   localparam int unsigned CTL_RX_SEL     = 2;
   localparam int unsigned CTL_TX_SEL     = 3;
   localparam int unsigned CTL_RUN        = 4;
   localparam int unsigned CTL_W          = 5;
   // Serial control, power control and timer 2 fields
   localparam int unsigned SER_HIGH       = 7;
   localparam int unsigned SER_LOW        = 6;
   localparam int unsigned PWR_VIEW       = 6;
   localparam int unsigned PWR_DOUBLER    = 7;
   localparam int unsigned T2_TX          = 0;
   localparam int unsigned T2_RX          = 1;

   // Reset values and counter constants
   localparam logic [7:0] RESET_RELOAD    = 8'h00;
   localparam logic [4:0] RESET_CONTROL   = 5'h00;
   localparam logic [7:0] COUNT_ALL_ONES  = 8'hFF;
   localparam logic [2:0] PRESCALE_LAST   = 3'(PRESCALE_DIV - 1);

   typedef enum logic [3:0] {
      URFC_SRC_T1  = 4'h1,
      URFC_SRC_T2  = 4'h2,
      URFC_SRC_GEN = 4'h4
   } urfc_src_t;

   // Generator select overrides the timer 2 select
   function automatic urfc_src_t urfc_pick(input logic gen_sel, input logic t2_sel);
      if (gen_sel)
         return URFC_SRC_GEN;
      else if (t2_sel)
         return URFC_SRC_T2;
      else
         return URFC_SRC_T1;
   endfunction

   function automatic logic urfc_raw(input urfc_src_t src, input logic gen_ovf,
                                     input logic t1_ovf, input logic t2_ovf);
      case (src)
         URFC_SRC_GEN: return gen_ovf;
         URFC_SRC_T2:  return t2_ovf;
         default:      return t1_ovf;
      endcase
   endfunction

endpackage

// ---- common/urfc_gen_if.sv ----
/*
   Carrier between the top, the rate counter and the clock selector.
   Assumes all signals live in the system clock domain.
*/
`timescale 1ns/1ns
interface urfc_gen_if;
   logic       run;
   logic       fast;
   logic [7:0] reload;
   logic [7:0] count;
   logic       ovf;
   modport gen (input run, input fast, input reload, output count, output ovf);
   modport ctl (output run, output fast, output reload, input count, input ovf);
   modport sel (input ovf);
endinterface

// ---- rtl/urfc_rate_counter.sv ----
/*
   Eight-bit reload counter with optional divide-by-six prescaler.
   Assumes run, fast and reload come from registers on clk_sys.
*/
`timescale 1ns/1ns
module urfc_rate_counter
   import urfc_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rst,
   urfc_gen_if.gen   gen
);

   logic [2:0] presc;
   logic       step;

   // Count enable, no timer prescaler involved
   assign step = gen.run && (gen.fast || presc == PRESCALE_LAST);

   always_ff @(posedge clk_sys) begin
      if (rst)
         presc <= 3'h0;
      else if (gen.run && !gen.fast)
         presc <= (presc == PRESCALE_LAST) ? 3'h0 : 3'(presc + 3'h1);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         gen.count <= 8'h00;
         gen.ovf   <= 1'b0;
      end else begin
         gen.ovf <= step && gen.count == COUNT_ALL_ONES;
         if (step) begin
            if (gen.count == COUNT_ALL_ONES)
               gen.count <= gen.reload;
            else
               gen.count <= 8'(gen.count + 8'h01);
         end
      end
   end

endmodule // urfc_rate_counter

// ---- rtl/urfc_clock_select.sv ----
/*
   Picks transmit, receive and shift-mode bit ticks from the sources.
   Assumes all tick inputs are one-cycle pulses on clk_sys.
*/
`timescale 1ns/1ns
module urfc_clock_select
   import urfc_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst,
   urfc_gen_if.sel         gen,
   input  wire logic       t1_ovf,
   input  wire logic       t2_ovf,
   input  wire logic       fixed_tick,
   input  wire logic       tx_gen_sel,
   input  wire logic       rx_gen_sel,
   input  wire logic       tx_t2_sel,
   input  wire logic       rx_t2_sel,
   input  wire logic       src_sel,
   input  wire logic [1:0] mode,
   input  wire logic       doubler,
   output logic            tx_sel_tick,
   output logic            rx_sel_tick,
   output logic            m0_sel_tick
);

   urfc_src_t tx_src;
   urfc_src_t rx_src;
   logic      tx_raw;
   logic      rx_raw;
   logic      tx_half;
   logic      rx_half;

   assign tx_src = urfc_pick(tx_gen_sel, tx_t2_sel);
   assign rx_src = urfc_pick(rx_gen_sel, rx_t2_sel);
   assign tx_raw = urfc_raw(tx_src, gen.ovf, t1_ovf, t2_ovf);
   assign rx_raw = urfc_raw(rx_src, gen.ovf, t1_ovf, t2_ovf);

   // Halve the generator and timer 1 rates unless doubled
   always_ff @(posedge clk_sys) begin
      if (rst)
         tx_half <= 1'b0;
      else if (tx_raw && tx_src != URFC_SRC_T2 && !doubler)
         tx_half <= !tx_half;
   end

   always_ff @(posedge clk_sys) begin
      if (rst)
         rx_half <= 1'b0;
      else if (rx_raw && rx_src != URFC_SRC_T2 && !doubler)
         rx_half <= !rx_half;
   end

   // Generator in modes 1 and 3 and, with the source bit set, shift mode 0; fixed rate in mode 2
   always_comb begin
      tx_sel_tick = 1'b0;
      rx_sel_tick = 1'b0;
      if (mode[0]) begin
         tx_sel_tick = tx_raw && (tx_src == URFC_SRC_T2 || doubler || tx_half);
         rx_sel_tick = rx_raw && (rx_src == URFC_SRC_T2 || doubler || rx_half);
      end else if (mode[1]) begin
         tx_sel_tick = fixed_tick;
         rx_sel_tick = fixed_tick;
      end
      m0_sel_tick = src_sel ? gen.ovf : fixed_tick;
   end

endmodule // urfc_clock_select

// ---- rtl/urfc_top.sv ----
/*
   UART rate generator and framing error flag with a Wishbone slave.
   Assumes a classic Wishbone master and receiver pulses on clk_sys.
*/
`timescale 1ns/1ns
// Functional notes
// - Rate generator is an eight-bit up-counter reloading from the reload register.
// - On wrap from all ones, load the reload value and count on.
// - Generator counts only while run is set; clear stops, set restarts.
// - Speed clear counts system clock over six; set counts every clock.
// - No timer prescaler effect; bit rate depends on the doubler bit.
// - Modes 1 and 3: rate is doubler-scaled clock over 32 times wrap.
// - Generator clocks modes 1 and 3, and mode 0 when the source bit is set, never the fixed mode 2.
// - Transmit select set uses generator; clear uses timer 1 or 2.
// - Receive select set uses generator; clear uses timer 1 or 2.
// - Generator selects override timer 2 selects, each direction independent.
// - Mode-0 source set clocks shift mode from generator, else fixed source.
// - Receiver checks each frame's stop bit; missing sets framing error.
// - Serial bit 7 is framing error when view set, else mode bit.
// - Framing error is sticky; only a software zero write while visible clears.
// - Framing error sets regardless of the view select bit.
// - With generator select clear, timer 2 select picks timer 2 else 1.
module urfc_top
   import urfc_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [DAT_W-1:0] wb_dat_i,
   output logic      [DAT_W-1:0] wb_dat_o,
   output logic                  wb_ack_o,
   input  wire logic             t1_ovf,
   input  wire logic             t2_ovf,
   input  wire logic             fixed_tick,
   input  wire logic             frame_end,
   input  wire logic             stop_bit,
   output logic                  tx_tick,
   output logic                  rx_tick,
   output logic                  mode0_tick,
   output logic      [1:0]       serial_mode,
   output logic                  rate_doubler
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations

   urfc_gen_if gen_bus ();

   logic [CNT_W-1:0] rate_reload_value;
   logic [CTL_W-1:0] rate_generator_control;
   logic             serial_mode_high_bit;
   logic             serial_mode_low_bit;
   logic             error_view_select;
   logic             timer2_transmit_select;
   logic             timer2_receive_select;
   logic             framing_error_flag;
   logic             next_framing_error_flag;
   logic             frame_bad;
   logic             req;
   logic             wr;
   logic             adr_ok;
   logic [7:0]       idx;
   logic [7:0]       wbyte;
   logic [7:0]       rbyte;
   logic             tx_sel_tick;
   logic             rx_sel_tick;
   logic             m0_sel_tick;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode

   assign req    = wb_cyc_i && wb_stb_i;
   assign idx    = wb_adr_i[9:2];
   assign adr_ok = wb_adr_i[ADR_W-1:10] == 2'h0 && wb_adr_i[1:0] == 2'h0;
   assign wr     = req && wb_we_i && wb_ack_o && wb_sel_i[0] && adr_ok;
   assign wbyte  = wb_dat_i[7:0];

   always_ff @(posedge clk_sys) begin
      if (rst)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= req && !wb_ack_o;
   end

   always_comb begin
      rbyte = 8'h00;
      if (adr_ok) begin
         case (idx)
            IDX_RELOAD:  rbyte = rate_reload_value;
            IDX_CONTROL: rbyte = {3'h0, rate_generator_control};
            IDX_SERIAL: begin
               rbyte[SER_HIGH] = error_view_select ? framing_error_flag
                                                   : serial_mode_high_bit;
               rbyte[SER_LOW]  = serial_mode_low_bit;
            end
            IDX_POWER: begin
               rbyte[PWR_DOUBLER] = rate_doubler;
               rbyte[PWR_VIEW]    = error_view_select;
            end
            IDX_TIMER2: begin
               rbyte[T2_TX] = timer2_transmit_select;
               rbyte[T2_RX] = timer2_receive_select;
            end
            IDX_COUNT:   rbyte = gen_bus.count;
            default:     rbyte = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst)
         wb_dat_o <= '0;
      else if (req && !wb_ack_o)
         wb_dat_o <= {24'h000000, rbyte};
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Generator registers

   always_ff @(posedge clk_sys) begin
      if (rst)
         rate_reload_value <= RESET_RELOAD;
      else if (wr && idx == IDX_RELOAD)
         rate_reload_value <= wbyte;
   end

   always_ff @(posedge clk_sys) begin
      if (rst)
         rate_generator_control <= RESET_CONTROL;
      else if (wr && idx == IDX_CONTROL)
         rate_generator_control <= wbyte[CTL_W-1:0];
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rate_doubler      <= 1'b0;
         error_view_select <= 1'b0;
      end else if (wr && idx == IDX_POWER) begin
         rate_doubler      <= wbyte[PWR_DOUBLER];
         error_view_select <= wbyte[PWR_VIEW];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         timer2_transmit_select <= 1'b0;
         timer2_receive_select  <= 1'b0;
      end else if (wr && idx == IDX_TIMER2) begin
         timer2_transmit_select <= wbyte[T2_TX];
         timer2_receive_select  <= wbyte[T2_RX];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Serial mode bits and framing error

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         serial_mode_high_bit <= 1'b0;
         serial_mode_low_bit  <= 1'b0;
      end else if (wr && idx == IDX_SERIAL) begin
         if (!error_view_select)
            serial_mode_high_bit <= wbyte[SER_HIGH];
         serial_mode_low_bit <= wbyte[SER_LOW];
      end
   end

   assign frame_bad = frame_end && !stop_bit;

   // Hardware set wins over a software clear in the same cycle
   always_comb begin
      next_framing_error_flag = framing_error_flag;
      if (wr && idx == IDX_SERIAL && error_view_select)
         next_framing_error_flag = wbyte[SER_HIGH];
      if (frame_bad)
         next_framing_error_flag = 1'b1;
   end

   always_ff @(posedge clk_sys) begin
      if (rst)
         framing_error_flag <= 1'b0;
      else
         framing_error_flag <= next_framing_error_flag;
   end

   always_ff @(posedge clk_sys) begin
      if (rst)
         serial_mode <= 2'h0;
      else
         serial_mode <= {serial_mode_high_bit, serial_mode_low_bit};
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Counter and clock selection

   assign gen_bus.run    = rate_generator_control[CTL_RUN];
   assign gen_bus.fast   = rate_generator_control[CTL_SPEED];
   assign gen_bus.reload = rate_reload_value;

   urfc_rate_counter u_counter (
      .clk_sys (clk_sys),
      .rst     (rst),
      .gen     (gen_bus.gen)
   );

   urfc_clock_select u_select (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .gen         (gen_bus.sel),
      .t1_ovf      (t1_ovf),
      .t2_ovf      (t2_ovf),
      .fixed_tick  (fixed_tick),
      .tx_gen_sel  (rate_generator_control[CTL_TX_SEL]),
      .rx_gen_sel  (rate_generator_control[CTL_RX_SEL]),
      .tx_t2_sel   (timer2_transmit_select),
      .rx_t2_sel   (timer2_receive_select),
      .src_sel     (rate_generator_control[CTL_SRC]),
      .mode        (serial_mode),
      .doubler     (rate_doubler),
      .tx_sel_tick (tx_sel_tick),
      .rx_sel_tick (rx_sel_tick),
      .m0_sel_tick (m0_sel_tick)
   );

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tx_tick    <= 1'b0;
         rx_tick    <= 1'b0;
         mode0_tick <= 1'b0;
      end else begin
         tx_tick    <= tx_sel_tick;
         rx_tick    <= rx_sel_tick;
         mode0_tick <= m0_sel_tick;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   a_wrap_reload: assert property (@(posedge clk_sys) disable iff (rst)
      gen_bus.ovf |-> gen_bus.count == $past(gen_bus.reload))
      else $error("counter did not reload on wrap");

   a_stop_hold: assert property (@(posedge clk_sys) disable iff (rst)
      (!gen_bus.run && $past(!gen_bus.run)) |-> ($stable(gen_bus.count) && !gen_bus.ovf))
      else $error("stopped counter moved");

   a_fast_step: assert property (@(posedge clk_sys) disable iff (rst)
      (gen_bus.run && gen_bus.fast && gen_bus.count != COUNT_ALL_ONES)
         |=> gen_bus.count == 8'($past(gen_bus.count) + 8'h01))
      else $error("fast counter missed a step");

   a_slow_rate: assert property (@(posedge clk_sys) disable iff (rst)
      (gen_bus.run && !gen_bus.fast && gen_bus.count != COUNT_ALL_ONES
         && $changed(gen_bus.count)) ##1 (gen_bus.run && !gen_bus.fast)[*5]
         |-> $stable(gen_bus.count))
      else $error("slow counter ran faster than one sixth");

   a_reload_quiet: assert property (@(posedge clk_sys) disable iff (rst)
      (wr && idx == IDX_RELOAD && !gen_bus.run) |=> $stable(gen_bus.count))
      else $error("reload write disturbed the count");

   a_fe_set: assert property (@(posedge clk_sys) disable iff (rst)
      frame_bad |=> framing_error_flag ##1 (framing_error_flag || $past(wr)))
      else $error("framing error not flagged");

   a_fe_sticky: assert property (@(posedge clk_sys) disable iff (rst)
      (framing_error_flag && !(wr && idx == IDX_SERIAL && error_view_select))
         |=> framing_error_flag)
      else $error("framing error cleared without software");

   a_view_read: assert property (@(posedge clk_sys) disable iff (rst)
      (req && !wb_ack_o && !wb_we_i && adr_ok && idx == IDX_SERIAL && error_view_select)
         |=> wb_dat_o[SER_HIGH] == $past(framing_error_flag))
      else $error("serial bit 7 did not show the error flag");

   a_tx_gen: assert property (@(posedge clk_sys) disable iff (rst)
      (serial_mode[0] && rate_generator_control[CTL_TX_SEL] && rate_doubler
         && gen_bus.ovf) |=> tx_tick)
      else $error("generator did not clock transmit");

   a_rx_timer2: assert property (@(posedge clk_sys) disable iff (rst)
      (serial_mode[0] && !rate_generator_control[CTL_RX_SEL] && timer2_receive_select
         && t2_ovf) |=> rx_tick)
      else $error("timer 2 did not clock receive");

   a_mode0_src: assert property (@(posedge clk_sys) disable iff (rst)
      (rate_generator_control[CTL_SRC] && gen_bus.ovf) |=> mode0_tick)
      else $error("generator did not clock shift mode");

   a_ack_once: assert property (@(posedge clk_sys) disable iff (rst)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   a_ack_reply: assert property (@(posedge clk_sys) disable iff (rst)
      (req && !wb_ack_o) |=> wb_ack_o)
      else $error("request not acknowledged");

   a_wrap_source: assert property (@(posedge clk_sys) disable iff (rst)
      gen_bus.ovf |-> ($past(gen_bus.count) == COUNT_ALL_ONES && $past(gen_bus.run)))
      else $error("overflow without a wrap");

   a_rx_gen: assert property (@(posedge clk_sys) disable iff (rst)
      (serial_mode[0] && rate_generator_control[CTL_RX_SEL] && rate_doubler
         && gen_bus.ovf) |=> rx_tick)
      else $error("generator did not clock receive");

   a_tx_timer2: assert property (@(posedge clk_sys) disable iff (rst)
      (serial_mode[0] && !rate_generator_control[CTL_TX_SEL] && timer2_transmit_select
         && t2_ovf) |=> tx_tick)
      else $error("timer 2 did not clock transmit");

   a_tx_timer1: assert property (@(posedge clk_sys) disable iff (rst)
      (serial_mode[0] && !rate_generator_control[CTL_TX_SEL] && !timer2_transmit_select
         && rate_doubler && t1_ovf) |=> tx_tick)
      else $error("timer 1 did not clock transmit");

   a_mode0_quiet: assert property (@(posedge clk_sys) disable iff (rst)
      (serial_mode == 2'h0) |=> (!tx_tick && !rx_tick))
      else $error("transfer ticks in shift mode");

   a_mode2_fixed: assert property (@(posedge clk_sys) disable iff (rst)
      (serial_mode == 2'h2)
         |=> (tx_tick == $past(fixed_tick) && rx_tick == $past(fixed_tick)))
      else $error("mode 2 not on the fixed rate");

   a_mode0_fixed: assert property (@(posedge clk_sys) disable iff (rst)
      (!rate_generator_control[CTL_SRC] && fixed_tick) |=> mode0_tick)
      else $error("fixed source did not clock shift mode");

   a_fe_clear: assert property (@(posedge clk_sys) disable iff (rst)
      (wr && idx == IDX_SERIAL && error_view_select && !wbyte[SER_HIGH] && !frame_bad)
         |=> !framing_error_flag)
      else $error("error flag clear lost");

   a_mode_write: assert property (@(posedge clk_sys) disable iff (rst)
      (wr && idx == IDX_SERIAL && !error_view_select)
         |=> serial_mode_high_bit == $past(wbyte[SER_HIGH]))
      else $error("mode bit write lost");

   a_mode_guard: assert property (@(posedge clk_sys) disable iff (rst)
      (wr && idx == IDX_SERIAL && error_view_select) |=> $stable(serial_mode_high_bit))
      else $error("flag write changed the mode bit");

endmodule // urfc_top

// ---- testbench/urfc_far_side.sv ----
/*
   Far-side serial peer: ends received frames with a good or missing stop bit.
   Assumes the bench calls send_frame from a process synchronised to clk_sys.
*/
`timescale 1ns/1ns
module urfc_far_side
(
   input  wire logic clk_sys,
   output logic      frame_end,
   output logic      stop_bit
);

   initial begin
      frame_end = 1'b0;
      stop_bit  = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One frame end, after lag cycles
   task automatic send_frame(input logic stop_ok, input int lag);
      repeat (lag) @(posedge clk_sys);
      frame_end <= 1'b1;
      stop_bit  <= stop_ok;
      @(posedge clk_sys);
      frame_end <= 1'b0;
      // Stale level not kept
      stop_bit  <= ~stop_ok;
   endtask

endmodule // urfc_far_side

// ---- testbench/urfc_top_tb.sv ----
/*
   Self-checking bench of the rate generator and frame check.
   Assumes urfc_top, the far-side model and a 100 MHz system clock.
*/
`timescale 1ns/1ns
module urfc_top_tb
   import urfc_pkg::*;
();

   logic             clk_sys    = 1'b0;
   logic             rst        = 1'b1;
   logic             wb_cyc_i   = 1'b0;
   logic             wb_stb_i   = 1'b0;
   logic             wb_we_i    = 1'b0;
   logic [ADR_W-1:0] wb_adr_i   = '0;
   logic [3:0]       wb_sel_i   = 4'h0;
   logic [DAT_W-1:0] wb_dat_i   = '0;
   logic [DAT_W-1:0] wb_dat_o;
   logic             wb_ack_o;
   logic             t1_ovf     = 1'b0;
   logic             t2_ovf     = 1'b0;
   logic             fixed_tick = 1'b0;
   logic             frame_end;
   logic             stop_bit;
   logic             tx_tick;
   logic             rx_tick;
   logic             mode0_tick;
   logic [1:0]       serial_mode;
   logic             rate_doubler;
   logic [2:0]       ticks;
   int               cyc_cnt    = 0;
   int               last_t[3]  = '{0, 0, 0};
   int               gap[3]     = '{0, 0, 0};
   int               seen[3]    = '{0, 0, 0};
   int               num_errors = 0;
   int               check_count = 0;

   always #5 clk_sys = ~clk_sys;
   assign ticks = {mode0_tick, rx_tick, tx_tick};

   urfc_top urfc_top_inst (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .t1_ovf(t1_ovf),
      .t2_ovf(t2_ovf), .fixed_tick(fixed_tick), .frame_end(frame_end),
      .stop_bit(stop_bit), .tx_tick(tx_tick), .rx_tick(rx_tick),
      .mode0_tick(mode0_tick), .serial_mode(serial_mode), .rate_doubler(rate_doubler));

   urfc_far_side urfc_far_side_inst (.clk_sys(clk_sys), .frame_end(frame_end),
      .stop_bit(stop_bit));

   ////////////////////////////////////////////////////////////////////////////
   // Timer pulses every 7 and 11, fixed tick every 5; tick gap tracking
   always @(posedge clk_sys) begin
      cyc_cnt    <= cyc_cnt + 1;
      t1_ovf     <= (cyc_cnt % 7 == 0);
      t2_ovf     <= (cyc_cnt % 11 == 0);
      fixed_tick <= (cyc_cnt % 5 == 0);
      for (int k = 0; k < 3; k++) begin
         if (ticks[k] === 1'b1) begin
            gap[k]    <= cyc_cnt - last_t[k];
            last_t[k] <= cyc_cnt;
            seen[k]   <= seen[k] + 1;
         end
      end
      if (cyc_cnt == 20000) begin
         num_errors++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic close_out();
      if (num_errors == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                          output logic [31:0] rd);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {2'b00, idx, 2'b00};
      wb_dat_i <= {24'h000000, wd};
      wb_sel_i <= 4'hF;
      rd = 32'h0;
      while (wb_ack_o !== 1'b1) @(posedge clk_sys);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge clk_sys);
      chk("ack dropped", 32'h0, {31'h0, wb_ack_o});
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
      logic [31:0] d;
      wb_xfer(1'b1, idx, wd, d);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] e);
      logic [31:0] d;
      wb_xfer(1'b0, idx, 8'h00, d);
      chk(what, e, d);
   endtask

   // Gap between the last two of n fresh ticks on source k, once in-flight ticks land
   task automatic tick_gap(input int k, input int n, input string what, input int e);
      int s;
      repeat (2) @(posedge clk_sys);
      s = seen[k];
      while (seen[k] < s + n) @(posedge clk_sys);
      chk(what, 32'(e), 32'(gap[k]));
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_regs();
      rd_chk("reload reset", IDX_RELOAD, 32'h0);
      rd_chk("control reset", IDX_CONTROL, 32'h0);
      wr(IDX_COUNT, 8'h55);
      rd_chk("count read only", IDX_COUNT, 32'h0);
      wr(8'h10, 8'h77);
      rd_chk("unmapped", 8'h10, 32'h0);
      wr(IDX_RELOAD, 8'hA5);
      rd_chk("reload rw", IDX_RELOAD, 32'hA5);
      wr(IDX_CONTROL, 8'hFF);
      rd_chk("control rw", IDX_CONTROL, 32'h1F);
   endtask

   task automatic t_rate();
      logic [7:0] rl[3] = '{8'hF3, 8'hFF, 8'h00};
      wr(IDX_POWER, 8'h80);
      wr(IDX_SERIAL, 8'h40);
      wr(IDX_TIMER2, 8'h00);
      chk("serial mode", 32'h1, {30'h0, serial_mode});
      chk("doubler out", 32'h1, {31'h0, rate_doubler});
      for (int i = 0; i < 3; i++) begin
         wr(IDX_RELOAD, rl[i]);
         wr(IDX_CONTROL, 8'h1A);
         tick_gap(0, 2, "fast gap", 256 - int'(rl[i]));
      end
      wr(IDX_RELOAD, 8'hF3);
      wr(IDX_CONTROL, 8'h18);
      tick_gap(0, 2, "slow gap", 6 * 13);
      wr(IDX_POWER, 8'h00);
      wr(IDX_CONTROL, 8'h1A);
      tick_gap(0, 3, "undoubled gap", 2 * 13);
      wr(IDX_POWER, 8'h80);
   endtask

   task automatic t_reload_mid();
      tick_gap(0, 1, "sync gap", 13);
      wr(IDX_RELOAD, 8'hF0);
      tick_gap(0, 1, "old reload gap", 13);
      tick_gap(0, 1, "new reload gap", 16);
   endtask

   task automatic t_run();
      logic [31:0] c1;
      int          s;
      wr(IDX_CONTROL, 8'h0A);
      wb_xfer(1'b0, IDX_COUNT, 8'h00, c1);
      s = seen[0];
      repeat (40) @(posedge clk_sys);
      rd_chk("held count", IDX_COUNT, c1);
      chk("ticks when stopped", 32'(s), 32'(seen[0]));
      wr(IDX_CONTROL, 8'h1A);
      tick_gap(0, 2, "restart gap", 16);
      wr(IDX_RELOAD, 8'hF3);
   endtask

   task automatic t_select();
      logic [3:0] i;
      for (int j = 0; j < 16; j++) begin
         i = 4'(j);
         wr(IDX_CONTROL, 8'h12 | {4'h0, i[3], i[2], 2'b00});
         wr(IDX_TIMER2, {6'h00, i[0], i[1]});
         tick_gap(0, 2, "tx source", i[3] ? 13 : (i[1] ? 11 : 7));
         tick_gap(1, 2, "rx source", i[2] ? 13 : (i[0] ? 11 : 7));
      end
   endtask

   task automatic t_mode0();
      wr(IDX_CONTROL, 8'h13);
      tick_gap(2, 2, "mode0 from generator", 13);
      wr(IDX_CONTROL, 8'h1A);
      tick_gap(2, 2, "mode0 fixed", 5);
      wr(IDX_SERIAL, 8'h80);
      tick_gap(0, 2, "mode 2 tx fixed", 5);
      wr(IDX_SERIAL, 8'h40);
   endtask

   task automatic t_frame();
      urfc_far_side_inst.send_frame(1'b0, 2);
      wr(IDX_POWER, 8'hC0);
      rd_chk("error set hidden", IDX_SERIAL, 32'hC0);
      urfc_far_side_inst.send_frame(1'b1, 0);
      rd_chk("error sticky", IDX_SERIAL, 32'hC0);
      wr(IDX_SERIAL, 8'h40);
      rd_chk("error cleared", IDX_SERIAL, 32'h40);
      chk("mode kept", 32'h1, {30'h0, serial_mode});
      urfc_far_side_inst.send_frame(1'b1, 3);
      rd_chk("good frame", IDX_SERIAL, 32'h40);
      wr(IDX_POWER, 8'h80);
      wr(IDX_SERIAL, 8'hC0);
      rd_chk("mode bit view", IDX_SERIAL, 32'hC0);
      chk("mode high out", 32'h3, {30'h0, serial_mode});
      wr(IDX_POWER, 8'hC0);
      rd_chk("error view", IDX_SERIAL, 32'h40);
      urfc_far_side_inst.send_frame(1'b0, 0);
      rd_chk("error visible", IDX_SERIAL, 32'hC0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      t_regs();
      t_rate();
      t_reload_mid();
      t_run();
      t_select();
      t_mode0();
      t_frame();
      close_out();
   end

endmodule // urfc_top_tb
